//--- src/lpga_amp_if.sv
// Bundle between the register bank and one amplifier gain stage.
// Assumes both ends run on the same reference clock.
`default_nettype none

interface lpga_amp_if;
  logic       loadStrobe;    // One-cycle pulse: take staged volume
  logic [2:0] stagedVol;
  logic       zcEnable;
  logic       zeroCrossEvt;  // One-cycle pulse per detected crossing
  logic       timeoutTick;
  logic [2:0] appliedVol;
  logic       pending;

  modport ctrl  (output loadStrobe, stagedVol, zcEnable, zeroCrossEvt, timeoutTick,
                 input appliedVol, pending);
  modport stage (input loadStrobe, stagedVol, zcEnable, zeroCrossEvt, timeoutTick,
                 output appliedVol, pending);
endinterface : lpga_amp_if

`default_nettype wire

//--- src/lpga_gain_stage.sv
// Applied gain of one amplifier: immediate or zero-cross gated load with timeout fallback.
// Assumes load, zero-cross and tick pulses are already synchronous to ref_clk.
`default_nettype none

module lpga_gain_stage (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  lpga_amp_if.stage amp
);
  import lpga_pkg::*;

  logic [2:0] pendingVol_reg;
  logic [1:0] tickCnt_reg;
  logic       applyNow;

  // Gated load completes on a crossing or after a full timeout period
  assign applyNow = amp.pending && (amp.zeroCrossEvt || (amp.timeoutTick && tickCnt_reg == TOUT_TICKS - 2'h1));

  // Applied volume
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      amp.appliedVol <= RST_VOL;
    end else if (amp.loadStrobe && !amp.zcEnable) begin
      amp.appliedVol <= amp.stagedVol;
    end else if (!amp.loadStrobe && applyNow) begin
      amp.appliedVol <= pendingVol_reg;
    end
  end

  // Pending load and timeout tick count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      amp.pending    <= 1'b0;
      pendingVol_reg <= RST_VOL;
      tickCnt_reg    <= 2'h0;
    end else if (amp.loadStrobe) begin
      amp.pending    <= amp.zcEnable;
      pendingVol_reg <= amp.stagedVol;
      tickCnt_reg    <= 2'h0;
    end else if (applyNow) begin
      amp.pending <= 1'b0;
      tickCnt_reg <= 2'h0;
    end else if (amp.pending && amp.timeoutTick) begin
      tickCnt_reg <= tickCnt_reg + 2'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_immediate_gain: assert property (amp.loadStrobe && !amp.zcEnable |=> amp.appliedVol == $past(amp.stagedVol))
    else $error("immediate gain change not applied");
  a_deferred_gain: assert property (amp.loadStrobe && amp.zcEnable |=> amp.pending && $stable(amp.appliedVol))
    else $error("gated gain change applied early");
  a_timeout_apply: assert property (amp.pending && !amp.loadStrobe && amp.timeoutTick && tickCnt_reg == 2'h1 |=>
                                    !amp.pending && amp.appliedVol == $past(pendingVol_reg))
    else $error("timeout did not apply pending gain");
  a_gain_holds: assert property (!amp.loadStrobe && !amp.pending |=> $stable(amp.appliedVol))
    else $error("applied gain changed without load");
  c_zc_apply: cover property (amp.pending && amp.zeroCrossEvt ##1 !amp.pending);
  c_timeout: cover property (amp.pending && !amp.loadStrobe && amp.timeoutTick && tickCnt_reg == 2'h1 ##1 !amp.pending);

endmodule : lpga_gain_stage

`default_nettype wire

//--- src/lpga_line_input_ctrl.sv
// Register bank and control for four line-input amplifiers in two input pairs.
// Assumes an upstream two-wire serial front end turns bus frames into the word-wide
// register strobes here, and analogue comparators give asynchronous zero-cross levels.
`default_nettype none

module lpga_line_input_ctrl #(
  parameter int TOUT_SLOW_CYC = lpga_pkg::TOUT_SLOW_CYCLES
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             regWrEn,
  input  wire logic             regRdEn,
  input  wire logic [6:0]       regAddr,
  input  wire logic [15:0]      regWrData,
  output logic      [15:0]      regRdData,
  output logic                  regRdValid,
  input  wire logic             timeoutClockEnable,
  input  wire logic             timeoutClockRate,
  input  wire logic [3:0]       zeroCrossAsync,
  output logic      [3:0]       ampEnable,
  output logic      [3:0]       ampMute,
  output logic      [3:0]       ampUsed,
  output logic      [1:0]       pinRouteDiff,
  output logic      [3:0][2:0]  ampVolCode,
  output logic      [3:0][6:0]  ampGainHalfDb
);
  import lpga_pkg::*;

  logic [3:0]                 pwrEnable_reg;
  logic [1:0]                 pairDiff_reg;
  logic [3:0]                 mute_reg;
  logic [3:0]                 zeroCross_reg;
  logic [3:0][2:0]            vol_reg;
  logic [1:0]                 loadPair_reg;
  logic [TOUT_CNT_WIDTH-1:0]  toutCnt_reg;
  logic [TOUT_CNT_WIDTH-1:0]  toutLimit;
  logic                       toutTick;
  logic [3:0]                 zcMeta_reg;
  logic [3:0]                 zcSync_reg;
  logic [3:0]                 zcLast_reg;
  logic [1:0]                 volIdx;
  logic                       wrVol;

  // True when the address hits one of the four volume registers
  function automatic logic isVolAddr(input logic [6:0] addr);
    isVolAddr = (addr >= ADDR_VOLUME_FIRST) && (addr <= ADDR_VOLUME_LAST);
  endfunction : isVolAddr

  // Amplifier index of a volume register address
  function automatic logic [1:0] volIndex(input logic [6:0] addr);
    logic [6:0] diff;
    diff     = addr - ADDR_VOLUME_FIRST;
    volIndex = diff[1:0];
  endfunction : volIndex

  // Applied gain in half-dB steps from code and pair mode
  function automatic logic [6:0] gainHalfDb(input logic [2:0] code, input logic singleEnded);
    gainHalfDb = 7'(GAIN_HALF_DB_TABLE[code] + (singleEnded ? SINGLE_ENDED_BOOST : 7'h00));
  endfunction : gainHalfDb

  assign volIdx = volIndex(regAddr);
  assign wrVol  = regWrEn && isVolAddr(regAddr);

  // Power management enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrEnable_reg <= RST_ENABLE;
    end else if (regWrEn && regAddr == ADDR_POWER_MGMT_TWO) begin
      pwrEnable_reg <= {regWrData[POS_ENABLE_TOP-3], regWrData[POS_ENABLE_TOP-2],
                        regWrData[POS_ENABLE_TOP-1], regWrData[POS_ENABLE_TOP]};
    end
  end

  // Pair mode bits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pairDiff_reg <= RST_DIFF;
    end else if (regWrEn && regAddr == ADDR_PAIR1_LINE_CTRL) begin
      pairDiff_reg[0] <= regWrData[POS_DIFF_SELECT];
    end else if (regWrEn && regAddr == ADDR_PAIR2_LINE_CTRL) begin
      pairDiff_reg[1] <= regWrData[POS_DIFF_SELECT];
    end
  end

  // Staged volume, mute and zero-cross settings
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mute_reg      <= RST_MUTE;
      zeroCross_reg <= RST_ZERO_CROSS;
      vol_reg       <= {4{RST_VOL}};
    end else if (wrVol) begin
      mute_reg[volIdx]      <= regWrData[POS_MUTE];
      zeroCross_reg[volIdx] <= regWrData[POS_ZERO_CROSS];
      vol_reg[volIdx]       <= regWrData[POS_VOL_LSB +: VOL_WIDTH];
    end
  end

  // Update strobe: one pulse per pair, the cycle after the write that carries it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loadPair_reg <= 2'h0;
    end else begin
      loadPair_reg <= 2'h0;
      if (wrVol && regWrData[POS_VOL_UPDATE]) begin
        loadPair_reg[volIdx[1]] <= 1'b1;
      end
    end
  end

  // Registered read port; update bit and unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      regRdData  <= 16'h0000;
      if (regRdEn) begin
        if (regAddr == ADDR_POWER_MGMT_TWO) begin
          regRdData[POS_ENABLE_TOP -: 4] <= {pwrEnable_reg[0], pwrEnable_reg[1], pwrEnable_reg[2], pwrEnable_reg[3]};
        end else if (regAddr == ADDR_PAIR1_LINE_CTRL) begin
          regRdData[POS_DIFF_SELECT] <= pairDiff_reg[0];
        end else if (regAddr == ADDR_PAIR2_LINE_CTRL) begin
          regRdData[POS_DIFF_SELECT] <= pairDiff_reg[1];
        end else if (isVolAddr(regAddr)) begin
          regRdData[POS_MUTE]                   <= mute_reg[volIdx];
          regRdData[POS_ZERO_CROSS]             <= zeroCross_reg[volIdx];
          regRdData[POS_VOL_LSB +: VOL_WIDTH]   <= vol_reg[volIdx];
        end
      end
    end
  end

  // Timeout clock divider: one-cycle tick at the selected rate while enabled
  assign toutLimit = timeoutClockRate ? TOUT_CNT_WIDTH'(TOUT_SLOW_CYC - 1) : TOUT_CNT_WIDTH'(TOUT_FAST_CYCLES - 1);
  assign toutTick  = timeoutClockEnable && (toutCnt_reg >= toutLimit);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      toutCnt_reg <= '0;
    end else if (!timeoutClockEnable || toutTick) begin
      toutCnt_reg <= '0;
    end else begin
      toutCnt_reg <= toutCnt_reg + TOUT_CNT_WIDTH'(1);
    end
  end

  // Zero-cross synchronisers and rising-edge detect
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      zcMeta_reg <= 4'h0;
      zcSync_reg <= 4'h0;
      zcLast_reg <= 4'h0;
    end else begin
      zcMeta_reg <= zeroCrossAsync;
      zcSync_reg <= zcMeta_reg;
      zcLast_reg <= zcSync_reg;
    end
  end

  // One gain stage per amplifier
  lpga_amp_if ampIf[4] ();

  for (genvar i = 0; i < 4; i++) begin : g_amp
    assign ampIf[i].loadStrobe   = loadPair_reg[i/2];
    assign ampIf[i].stagedVol    = vol_reg[i];
    assign ampIf[i].zcEnable     = zeroCross_reg[i];
    assign ampIf[i].zeroCrossEvt = zcSync_reg[i] && !zcLast_reg[i];
    assign ampIf[i].timeoutTick  = toutTick;
    assign ampVolCode[i]         = ampIf[i].appliedVol;

    lpga_gain_stage u_stage (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .amp     (ampIf[i])
    );

    // Applied gain including single-ended boost
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        ampGainHalfDb[i] <= GAIN_HALF_DB_TABLE[RST_VOL];
      end else begin
        ampGainHalfDb[i] <= gainHalfDb(ampIf[i].appliedVol, !pairDiff_reg[i/2]);
      end
    end
  end

  // Pin routing and amplifier use: second amp of a pair is idle in differential mode
  assign pinRouteDiff = pairDiff_reg;
  assign ampEnable    = pwrEnable_reg;
  assign ampMute      = mute_reg;
  assign ampUsed      = {pwrEnable_reg[3] && !pairDiff_reg[1], pwrEnable_reg[2],
                         pwrEnable_reg[1] && !pairDiff_reg[0], pwrEnable_reg[0]};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_diff_select: assert property (regWrEn && regAddr == ADDR_PAIR1_LINE_CTRL |=>
                                  pinRouteDiff[0] == $past(regWrData[POS_DIFF_SELECT]) ##1 $stable(pinRouteDiff[0]) || regWrEn)
    else $error("pair mode bit not taken");
  a_second_idle: assert property (pinRouteDiff[1] |-> !ampUsed[3])
    else $error("second amp used in differential mode");
  a_enable_order: assert property (regWrEn && regAddr == ADDR_POWER_MGMT_TWO |=>
                                   ampEnable[0] == $past(regWrData[7]) && ampEnable[3] == $past(regWrData[4]))
    else $error("enable bit order wrong");
  a_se_boost: assert property (ampGainHalfDb[0] == 7'($past(gainHalfDb(ampVolCode[0], 1'b0)) +
                               ($past(pairDiff_reg[0]) ? 7'h00 : SINGLE_ENDED_BOOST)))
    else $error("single-ended boost wrong");
  a_mute_write: assert property (regWrEn && regAddr == ADDR_VOLUME_FIRST |=> ampMute[0] == $past(regWrData[POS_MUTE]))
    else $error("mute bit not taken");
  a_store_only: assert property (wrVol && !regWrData[POS_VOL_UPDATE] && loadPair_reg == 2'h0 |=> loadPair_reg == 2'h0)
    else $error("volume write without update loaded gain");
  a_pair_update: assert property (regWrEn && regAddr == 7'h19 && regWrData[POS_VOL_UPDATE] |=>
                                  loadPair_reg == 2'h1 ##1 loadPair_reg == 2'h0)
    else $error("update strobe not one pulse to pair one");
  a_update_reads0: assert property (regRdValid |-> !regRdData[POS_VOL_UPDATE])
    else $error("update bit reads back set");
  a_read_volume: assert property (regRdEn && regAddr == ADDR_VOLUME_LAST && !wrVol |=>
                                  regRdData[2:0] == vol_reg[3])
    else $error("volume readback wrong");

  // Use of the amplifiers follows enable and pair mode
  a_first_used: assert property (ampUsed[0] == ampEnable[0] && ampUsed[2] == ampEnable[2])
    else $error("first amp use does not follow enable");
  a_second_used: assert property (!pinRouteDiff[0] |-> ampUsed[1] == ampEnable[1])
    else $error("second amp not used in single-ended mode");

  // Settled differential gain matches the code table
  a_diff_gain: assert property (pinRouteDiff[1] && $stable(pinRouteDiff[1]) && $stable(ampVolCode[2]) |->
                                ampGainHalfDb[2] == GAIN_HALF_DB_TABLE[ampVolCode[2]])
    else $error("differential gain does not match code");

  // Divider tick is a single-cycle pulse
  a_tick_single: assert property (toutTick |=> !toutTick)
    else $error("timeout tick longer than one cycle");

  // Update from the second register of pair two strobes that pair
  a_pair2_update: assert property (regWrEn && regAddr == ADDR_VOLUME_LAST && regWrData[POS_VOL_UPDATE] |=>
                                   loadPair_reg[1])
    else $error("update strobe missing for pair two");

  // Settings hold while no write arrives
  a_regs_hold: assert property (!regWrEn |=> $stable(pwrEnable_reg) && $stable(pairDiff_reg) && $stable(vol_reg))
    else $error("register changed without a write");

  // Read answer comes exactly one cycle after the strobe
  a_read_valid: assert property (regRdEn |=> regRdValid)
    else $error("read answer missing");

  c_pair1_load: cover property (loadPair_reg[0]);
  c_pair2_load: cover property (loadPair_reg[1]);
  c_single_ended: cover property (!pinRouteDiff[0] && ampUsed[1]);
  c_gated_apply: cover property (ampIf[2].pending ##1 !ampIf[2].pending);

endmodule : lpga_line_input_ctrl

`default_nettype wire

//--- src/lpga_pkg.sv
// Constants for the line-input amplifier control block: register map, fields, resets, timing.
// Assumes a 40 MHz reference clock and a 7-bit register address with 16-bit data words.
`default_nettype none

package lpga_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_POWER_MGMT_TWO = 7'h02;
  localparam logic [6:0] ADDR_PAIR1_LINE_CTRL = 7'h16;
  localparam logic [6:0] ADDR_PAIR2_LINE_CTRL = 7'h17;
  localparam logic [6:0] ADDR_VOLUME_FIRST   = 7'h18;  // Four volume registers follow in order
  localparam logic [6:0] ADDR_VOLUME_LAST    = 7'h1B;

  // Field positions
  localparam int POS_ENABLE_TOP   = 7;  // Enables at 7..4, first amp of pair 1 highest
  localparam int POS_DIFF_SELECT  = 1;
  localparam int POS_VOL_UPDATE   = 8;
  localparam int POS_MUTE         = 7;
  localparam int POS_ZERO_CROSS   = 6;
  localparam int POS_VOL_LSB      = 0;
  localparam int VOL_WIDTH        = 3;

  // Reset values
  localparam logic [3:0] RST_ENABLE    = 4'h0;
  localparam logic [1:0] RST_DIFF      = 2'h3;
  localparam logic [3:0] RST_MUTE      = 4'hF;
  localparam logic [3:0] RST_ZERO_CROSS = 4'h0;
  localparam logic [2:0] RST_VOL       = 3'h3;

  // Gain per code in half-dB steps, differential mode, two's complement
  localparam logic [7:0][6:0] GAIN_HALF_DB_TABLE =
    {7'h24, 7'h24, 7'h18, 7'h0C, 7'h07, 7'h00, 7'h79, 7'h74};
  localparam logic [6:0] SINGLE_ENDED_BOOST = 7'h0C;  // Extra +6dB

  // Timeout clock
  localparam int REF_CLK_MHZ        = 40;
  localparam int TOUT_FAST_US       = 64;
  localparam int TOUT_SLOW_US       = 256;
  localparam int TOUT_FAST_CYCLES   = TOUT_FAST_US * REF_CLK_MHZ;
  localparam int TOUT_SLOW_CYCLES   = TOUT_SLOW_US * REF_CLK_MHZ;
  localparam int TOUT_CNT_WIDTH     = 14;
  localparam logic [1:0] TOUT_TICKS = 2'h2;  // Ticks that make one timeout period

endpackage : lpga_pkg

`default_nettype wire

//--- verification/lpga_host_model.sv
// Host side of the register port: word writes and reads as the serial front end delivers them.
// Assumes inputs change on the falling edge; input clamps, midrail and bias are handled elsewhere.
`default_nettype none

module lpga_host_model (
  input  wire logic        ref_clk,
  output var  logic        regWrEn,
  output var  logic        regRdEn,
  output var  logic [6:0]  regAddr,
  output var  logic [15:0] regWrData,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port at time zero
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 7'h00;
    regWrData = 16'h0000;
  end

  // One write strobe; released lines show the inverse of the last value
  task automatic wr(input logic [6:0] addr, input logic [15:0] data);
    @(negedge ref_clk);
    regWrEn   = 1'b1;
    regAddr   = addr;
    regWrData = data;
    @(negedge ref_clk);
    regWrEn   = 1'b0;
    regAddr   = ~addr;
    regWrData = ~data;
  endtask : wr

  // One read strobe; data and valid stand only in the cycle after the strobe edge
  task automatic rd(input logic [6:0] addr, output logic [15:0] data, output logic valid);
    @(negedge ref_clk);
    regRdEn = 1'b1;
    regAddr = addr;
    @(negedge ref_clk);
    data    = regRdData;
    valid   = regRdValid;
    regRdEn = 1'b0;
    regAddr = ~addr;
  endtask : rd
endmodule : lpga_host_model

`default_nettype wire

//--- verification/lpga_line_input_ctrl_tb_top.sv
// Self-checking bench for the line-input amplifier control block.
// Assumes the host model drives the register port and the bench drives the rest on falling edges.
`default_nettype none

module lpga_line_input_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lpga_pkg::*;

  localparam int SLOW_CYC = 40;  // Short slow timeout period for simulation
  localparam logic [7:0][6:0] GAIN_EXP = {7'h24, 7'h24, 7'h18, 7'h0C, 7'h07, 7'h00, 7'h79, 7'h74};

  logic            ref_clk;
  logic            rst_b;
  logic            regWrEn;
  logic            regRdEn;
  logic [6:0]      regAddr;
  logic [15:0]     regWrData;
  logic [15:0]     regRdData;
  logic            regRdValid;
  logic            timeoutClockEnable;
  logic            timeoutClockRate;
  logic [3:0]      zeroCrossAsync;
  logic [3:0]      ampEnable;
  logic [3:0]      ampMute;
  logic [3:0]      ampUsed;
  logic [1:0]      pinRouteDiff;
  logic [3:0][2:0] ampVolCode;
  logic [3:0][6:0] ampGainHalfDb;
  int              miscompares;
  int              check_count;

  lpga_line_input_ctrl #(.TOUT_SLOW_CYC(SLOW_CYC)) lpga_line_input_ctrl_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .timeoutClockEnable(timeoutClockEnable), .timeoutClockRate(timeoutClockRate),
    .zeroCrossAsync(zeroCrossAsync), .ampEnable(ampEnable), .ampMute(ampMute), .ampUsed(ampUsed),
    .pinRouteDiff(pinRouteDiff), .ampVolCode(ampVolCode), .ampGainHalfDb(ampGainHalfDb)
  );

  lpga_host_model lpga_host_model_inst (
    .ref_clk(ref_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid)
  );

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Read a register and compare data and valid
  task automatic rd_check(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] data;
    logic        valid;
    lpga_host_model_inst.rd(addr, data, valid);
    check("read valid", 16'h0001, {15'h0000, valid});
    check($sformatf("register %h", addr), exp, data);
  endtask : rd_check

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    rst_b = 1'b0;
    timeoutClockEnable = 1'b0;
    timeoutClockRate = 1'b0;
    zeroCrossAsync = 4'h0;
    cyc(6);
    rst_b = 1'b1;
    // Reset state at the ports and in the registers
    check("mute", 16'h000F, {12'h000, ampMute});
    check("route", 16'h0003, {14'h0000, pinRouteDiff});
    check("enable", 16'h0000, {12'h000, ampEnable});
    for (int i = 0; i < 4; i++) begin
      check("vol", 16'h0003, {13'h0000, ampVolCode[i]});
      check("gain", 16'h0007, {9'h000, ampGainHalfDb[i]});
    end
    rd_check(ADDR_POWER_MGMT_TWO, 16'h0000);
    rd_check(ADDR_PAIR1_LINE_CTRL, 16'h0002);
    rd_check(ADDR_PAIR2_LINE_CTRL, 16'h0002);
    for (int a = 0; a < 4; a++) rd_check(7'h18 + 7'(a), 16'h0083);
    // Unmapped place ignores writes and reads zero
    lpga_host_model_inst.wr(7'h03, 16'hFFFF);
    rd_check(7'h03, 16'h0000);
    // Enable bit order, then all four; differential uses first amps only
    lpga_host_model_inst.wr(ADDR_POWER_MGMT_TWO, 16'h0080);
    cyc(2);
    check("enable", 16'h0001, {12'h000, ampEnable});
    lpga_host_model_inst.wr(ADDR_POWER_MGMT_TWO, 16'h00F0);
    cyc(2);
    check("enable", 16'h000F, {12'h000, ampEnable});
    check("used", 16'h0005, {12'h000, ampUsed});
    rd_check(ADDR_POWER_MGMT_TWO, 16'h00F0);
    // Staged write, then pair update from the other register
    lpga_host_model_inst.wr(7'h18, 16'h0005);
    cyc(4);
    check("vol0", 16'h0003, {13'h0000, ampVolCode[0]});
    check("mute", 16'h000E, {12'h000, ampMute});
    rd_check(7'h18, 16'h0005);
    lpga_host_model_inst.wr(7'h19, 16'h0106);
    cyc(4);
    check("vol0", 16'h0005, {13'h0000, ampVolCode[0]});
    check("vol1", 16'h0006, {13'h0000, ampVolCode[1]});
    check("gain0", 16'h0018, {9'h000, ampGainHalfDb[0]});
    check("gain1", 16'h0024, {9'h000, ampGainHalfDb[1]});
    rd_check(7'h19, 16'h0006);
    // Pair 1 single-ended: both amps used, extra 6dB
    lpga_host_model_inst.wr(ADDR_PAIR1_LINE_CTRL, 16'h0000);
    cyc(4);
    check("route", 16'h0002, {14'h0000, pinRouteDiff});
    check("used", 16'h0007, {12'h000, ampUsed});
    check("gain0", 16'h0024, {9'h000, ampGainHalfDb[0]});
    check("gain1", 16'h0030, {9'h000, ampGainHalfDb[1]});
    rd_check(ADDR_PAIR1_LINE_CTRL, 16'h0000);
    // Every volume code on a differential amp, update set each time
    for (int c = 0; c < 8; c++) begin
      lpga_host_model_inst.wr(7'h1A, 16'h0100 | 16'(c));
      cyc(4);
      check("gain2", {9'h000, GAIN_EXP[c]}, {9'h000, ampGainHalfDb[2]});
    end
    // Zero-cross gated load waits for a crossing
    lpga_host_model_inst.wr(7'h1A, 16'h0141);
    cyc(8);
    check("vol2", 16'h0007, {13'h0000, ampVolCode[2]});
    zeroCrossAsync = 4'h4;
    cyc(8);
    check("vol2", 16'h0001, {13'h0000, ampVolCode[2]});
    zeroCrossAsync = 4'h0;
    // Timeout fallback at slow then fast rate
    timeoutClockEnable = 1'b1;
    timeoutClockRate = 1'b1;
    lpga_host_model_inst.wr(7'h1B, 16'h0144);
    cyc(3);
    check("vol3", 16'h0003, {13'h0000, ampVolCode[3]});
    cyc(2 * SLOW_CYC + 10);
    check("vol3", 16'h0004, {13'h0000, ampVolCode[3]});
    timeoutClockRate = 1'b0;
    lpga_host_model_inst.wr(7'h1B, 16'h0142);
    cyc(100);
    check("vol3", 16'h0004, {13'h0000, ampVolCode[3]});
    cyc(2 * TOUT_FAST_CYCLES + 10);
    check("vol3", 16'h0002, {13'h0000, ampVolCode[3]});
    test_done();
  end
endmodule : lpga_line_input_ctrl_tb_top

`default_nettype wire
